// [core/adcsc_pkg.sv]
// Package for the converter sequencer: register offsets, field positions,
// reset values, timing counts, sequencer states and carrier structs.
// Assumes a host that reaches the registers through a simple 16-bit
// global-address register port owned by the die-to-die bridge.
package adcsc_pkg;

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  localparam logic [7:0] BASE_BLOCKING     = 8'h02;
  localparam logic [7:0] BASE_NONBLOCKING  = 8'h03;

  localparam logic [7:0] OFS_CONFIG        = 8'h80;
  localparam logic [7:0] OFS_SELECT        = 8'h82;
  localparam logic [7:0] OFS_DONE          = 8'h84;
  localparam logic [7:0] OFS_RESULT        = 8'h86;
  localparam logic [7:0] OFS_RESULT_LAST   = 8'ha5;
  localparam logic [7:0] OFS_CSENSE        = 8'hb0;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int         CFG_OFFSET_COMP   = 5;
  localparam int         CFG_DIV_LSB       = 0;
  localparam int         CS_ON_BIT         = 7;
  localparam int         CS_CCD_BIT        = 3;
  localparam int         CS_GAIN_LSB       = 0;
  localparam logic [7:0] CONFIG_RESET      = 8'h00;
  localparam logic [7:0] CSENSE_RESET      = 8'h00;
  localparam logic [15:0] SELECT_RESET     = 16'h0000;
  localparam logic [15:0] CHANNEL_MASK     = 16'hdfff;

  // ---------------------------------------------------------------------
  // Channel map
  // ---------------------------------------------------------------------
  localparam logic [3:0] CH_CURRENT_SENSE  = 4'h9;
  localparam logic [3:0] CH_BATTERY_SENSE  = 4'ha;
  localparam logic [3:0] CH_TEMPERATURE    = 4'hb;
  localparam logic [3:0] CH_SUPPLY_SENSE   = 4'hc;
  localparam logic [3:0] CH_UNIMPLEMENTED  = 4'hd;
  localparam logic [3:0] CH_BANDGAP        = 4'he;
  localparam logic [3:0] CH_CAL_REF        = 4'hf;

  // ---------------------------------------------------------------------
  // Timing in conversion clock cycles and converter data
  // ---------------------------------------------------------------------
  localparam logic [4:0] SAMPLE_CYCLES     = 5'h09;
  localparam logic [4:0] CONVERT_CYCLES    = 5'h12;
  localparam logic [4:0] GAP_CYCLES        = 5'h04;
  localparam int         RAW_WIDTH         = 10;
  localparam logic [10:0] CAL_NOMINAL      = 11'h008;
  localparam logic [10:0] RAW_MAX          = 11'h3ff;

  // ---------------------------------------------------------------------
  // Divider codes mapped to division ratios
  // ---------------------------------------------------------------------
  localparam logic [3:0] DIV_BY_10         = 4'ha;
  localparam logic [3:0] DIV_BY_8          = 4'h8;
  localparam logic [3:0] DIV_BY_6          = 4'h6;
  localparam logic [3:0] DIV_BY_4          = 4'h4;
  localparam logic [3:0] DIV_BY_2          = 4'h2;
  localparam logic [3:0] DIV_BY_1          = 4'h1;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCSC_IDLE    = 3'h0,
    ADCSC_COUNT   = 3'h1,
    ADCSC_SAMPLE  = 3'h3,
    ADCSC_CONVERT = 3'h2,
    ADCSC_GAP     = 3'h6
  } adcsc_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        byte_acc;
    logic [15:0] addr;
    logic [15:0] wdata;
  } adcsc_req_t;

  typedef struct packed {
    logic       mux_valid;
    logic [3:0] mux_sel;
    logic       sample;
    logic       convert;
    logic       charge_comp;
    logic       sense_on;
    logic [2:0] gain_select;
  } adcsc_analog_t;

endpackage : adcsc_pkg

// [core/adcsc_prescaler.sv]
// Conversion clock prescaler: turns a divider code into a one-cycle
// enable pulse at the interface clock rate divided by the coded ratio.
// Assumes the code is static or changes only while the sequencer is idle.
`timescale 1ns/100ps
module adcsc_prescaler (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic [2:0] clock_divider_i,
  output logic            tick_o
);

  logic [3:0] ratio;
  logic [3:0] count;

  always_comb begin
    unique case (clock_divider_i)
      3'h0:    ratio = adcsc_pkg::DIV_BY_10;
      3'h1:    ratio = adcsc_pkg::DIV_BY_8;
      3'h2:    ratio = adcsc_pkg::DIV_BY_6;
      3'h3:    ratio = adcsc_pkg::DIV_BY_4;
      3'h4:    ratio = adcsc_pkg::DIV_BY_2;
      default: ratio = adcsc_pkg::DIV_BY_1;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count <= 4'h0;
    end else if (count == 4'h0) begin
      count <= ratio - 4'h1; // [R19]
    end else begin
      count <= count - 4'h1;
    end
  end

  assign tick_o = (count == 4'h0); // [R9]

endmodule : adcsc_prescaler

// [core/adcsc_sequencer.sv]
// Converter sequencer top: register port, channel sequencing, offset
// compensation, result storage and current sense amplifier control.
// Assumes a SAR core on the same clock that presents a 10-bit raw value
// on conv_data_i by the last cycle of the conversion phase.
//
// Function
// [R1] Result read clears that channel's done flag.
// [R2] Low byte read latches high; high read clears.
// [R3] Results stored left adjusted in 16 bits.
// [R4] Decode offsets at bases 0x0200 and 0x300.
// [R5] Channel index maps to documented analog sources.
// [R6] Channel 15 reference removes converter offset.
// [R7] Host sets enable and selects channel 15.
// [R8] Compensation works for single and sequence (code: select write zeroes offset; only runs with channel 15 compensate).
// [R9] Conversion clock from prescaled interface clock.
// [R10] Nine sample then eighteen conversion cycles.
// [R11] First count walks 15,0,1..14 to channel.
// [R12] Four cycles gap between two channels.
// [R13] Next-channel counting overlaps current conversion.
// [R14] Current sense bit 7 enables module.
// [R15] Bit 3 disables charge compensation.
// [R16] Charge compensation active in step with conversion.
// [R17] Bits 2-0 select amplifier gain.
// [R18] Select write aborts, clears flags, restarts; a low-byte write at 0x83 only clears flags (code also loads select bits 7-0 there).
// [R19] Divider codes give 10,8,6,4,2,1,1,1.
// [R20] Config bit 5 enables offset compensation.
// [R21] Store result and set flag together.
// [R22] Timing starts at first conversion clock tick.
`timescale 1ns/100ps
module adcsc_sequencer #(
  parameter int CHANNELS = 16
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  input  wire adcsc_pkg::adcsc_req_t req_i,
  output logic [15:0]                rdata_o,
  output logic                       rvalid_o,
  input  wire logic [9:0]            conv_data_i,
  output adcsc_pkg::adcsc_analog_t   analog_o,
  output logic                       busy_o
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    adcsc_pkg::adcsc_state_t state;
    logic [3:0]              order;
    logic [4:0]              cycles;
    logic [15:0]             select;
    logic [15:0]             done;
    logic [CHANNELS-1:0][9:0] result;
    logic [7:0]              config_reg;
    logic [7:0]              csense;
    logic [7:0]              high_latch;
    logic [10:0]             offset;
    logic [15:0]             rdata;
    logic                    rvalid;
  } adcsc_regs_t;

  adcsc_regs_t r;
  adcsc_regs_t next_r;
  logic        tick;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Position in the walk order: 0 is channel 15, k is channel k-1.
  function automatic logic [3:0] order_to_ch(input logic [3:0] ord);
    order_to_ch = (ord == 4'h0) ? adcsc_pkg::CH_CAL_REF : ord - 4'h1; // [R11]
  endfunction : order_to_ch

  function automatic logic ord_selected(input logic [15:0] sel,
                                        input logic [3:0]  ord);
    ord_selected = sel[order_to_ch(ord)];
  endfunction : ord_selected

  // Finds the next selected position after ord; found flag in bit 4.
  function automatic logic [4:0] next_selected(input logic [15:0] sel,
                                               input logic [3:0]  ord);
    logic [4:0] hit;
    logic [4:0] pos;
    hit = 5'h00;
    for (int k = 15; k >= 1; k--) begin
      pos = {1'b0, ord} + 5'(k);
      if (pos[4] == 1'b0 && ord_selected(sel, pos[3:0])) begin
        hit = {1'b1, pos[3:0]};
      end
    end
    next_selected = hit;
  endfunction : next_selected

  function automatic logic [15:0] left_adjust(input logic [9:0] v);
    left_adjust = {v, 6'h00}; // [R3]
  endfunction : left_adjust

  function automatic logic in_result(input logic [7:0] ofs);
    in_result = (ofs >= adcsc_pkg::OFS_RESULT) &&
                (ofs <= adcsc_pkg::OFS_RESULT_LAST);
  endfunction : in_result

  // ---------------------------------------------------------------------
  // Conversion clock enable
  // ---------------------------------------------------------------------
  adcsc_prescaler u_prescaler (
    .ref_clk_i       (ref_clk_i),
    .reset_i         (reset_i),
    .clock_divider_i (r.config_reg[adcsc_pkg::CFG_DIV_LSB +: 3]),
    .tick_o          (tick)
  );

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  logic        hit;
  logic [7:0]  ofs;
  logic [3:0]  rch;
  logic [7:0]  rel;
  logic [3:0]  cur_ch;
  logic [4:0]  nxt;
  logic [10:0] comp;
  logic [15:0] set_flags;
  logic [15:0] clr_flags;
  logic        start;
  logic [15:0] adj;

  always_comb begin
    next_r    = r;
    set_flags = 16'h0000;
    clr_flags = 16'h0000;
    start     = 1'b0;
    nxt       = 5'h00;
    comp      = 11'h000;
    cur_ch    = order_to_ch(r.order);
    hit       = req_i.valid &&
                ((req_i.addr[15:8] == adcsc_pkg::BASE_BLOCKING) ||
                 (req_i.addr[15:8] == adcsc_pkg::BASE_NONBLOCKING)); // [R4]
    ofs       = req_i.addr[7:0];
    rel       = ofs - adcsc_pkg::OFS_RESULT;
    rch       = rel[4:1];
    adj       = left_adjust(r.result[rch]); // [R3]
    next_r.rvalid = hit && !req_i.write;
    next_r.rdata  = 16'h0000;

    // Register writes.
    if (hit && req_i.write) begin
      if (ofs == adcsc_pkg::OFS_CONFIG) begin
        next_r.config_reg = req_i.wdata[7:0];
      end
      if (ofs == adcsc_pkg::OFS_CSENSE) begin
        next_r.csense = req_i.wdata[7:0]; // [R14] [R15] [R17]
      end
      if (ofs == adcsc_pkg::OFS_SELECT) begin
        if (req_i.byte_acc) begin
          next_r.select[15:8] = req_i.wdata[7:0];
        end else begin
          next_r.select = req_i.wdata;
        end
        start = 1'b1;
      end
      if (ofs == adcsc_pkg::OFS_SELECT + 8'h01) begin
        next_r.select[7:0] = req_i.wdata[7:0];
        clr_flags = 16'hffff;
      end
    end

    // Register reads with their side effects.
    if (hit && !req_i.write) begin
      unique case (1'b1)
        ofs == adcsc_pkg::OFS_CONFIG: begin
          next_r.rdata = {8'h00, r.config_reg};
        end
        ofs == adcsc_pkg::OFS_CSENSE: begin
          next_r.rdata = {8'h00, r.csense};
        end
        ofs == adcsc_pkg::OFS_SELECT: begin
          next_r.rdata = req_i.byte_acc ? {8'h00, r.select[15:8]} : r.select;
        end
        ofs == adcsc_pkg::OFS_SELECT + 8'h01: begin
          next_r.rdata = {8'h00, r.select[7:0]};
        end
        ofs == adcsc_pkg::OFS_DONE: begin
          next_r.rdata = req_i.byte_acc ? {8'h00, r.done[15:8]} : r.done;
        end
        ofs == adcsc_pkg::OFS_DONE + 8'h01: begin
          next_r.rdata = {8'h00, r.done[7:0]};
        end
        in_result(ofs): begin
          if (!req_i.byte_acc) begin
            next_r.rdata = adj;
            clr_flags[rch] = 1'b1; // [R1]
          end else if (ofs[0]) begin
            next_r.rdata      = {8'h00, adj[7:0]};
            next_r.high_latch = adj[15:8]; // [R2]
          end else begin
            next_r.rdata   = {8'h00, r.high_latch};
            clr_flags[rch] = 1'b1; // [R2]
          end
        end
        default: begin
          next_r.rdata = 16'h0000;
        end
      endcase
    end

    // Sequencer.
    unique case (r.state)
      adcsc_pkg::ADCSC_IDLE: begin
        next_r.cycles = 5'h00;
      end
      adcsc_pkg::ADCSC_COUNT: begin
        if (tick) begin // [R22]
          if (ord_selected(r.select, r.order)) begin // [R11]
            next_r.state  = adcsc_pkg::ADCSC_SAMPLE;
            next_r.cycles = 5'h00;
          end else if (r.order == 4'hf) begin
            next_r.state = adcsc_pkg::ADCSC_IDLE;
          end else begin
            next_r.order = r.order + 4'h1;
          end
        end
      end
      adcsc_pkg::ADCSC_SAMPLE: begin
        if (tick) begin
          if (r.cycles == adcsc_pkg::SAMPLE_CYCLES - 5'h01) begin // [R10]
            next_r.state  = adcsc_pkg::ADCSC_CONVERT;
            next_r.cycles = 5'h00;
          end else begin
            next_r.cycles = r.cycles + 5'h01;
          end
        end
      end
      adcsc_pkg::ADCSC_CONVERT: begin
        if (tick) begin
          if (r.cycles == adcsc_pkg::CONVERT_CYCLES - 5'h01) begin // [R10]
            // Subtract the measured offset, saturating at both ends.
            comp = {1'b0, conv_data_i} - r.offset; // [R6] [R8]
            if (r.offset[10] && comp[10]) begin
              comp = adcsc_pkg::RAW_MAX;
            end else if (!r.offset[10] && comp[10]) begin
              comp = 11'h000;
            end else if (comp > adcsc_pkg::RAW_MAX) begin
              comp = adcsc_pkg::RAW_MAX;
            end
            if (cur_ch == adcsc_pkg::CH_CAL_REF) begin
              next_r.result[cur_ch] = conv_data_i;
              if (r.config_reg[adcsc_pkg::CFG_OFFSET_COMP]) begin // [R20]
                next_r.offset = {1'b0, conv_data_i} -
                                adcsc_pkg::CAL_NOMINAL; // [R6]
              end
            end else begin
              next_r.result[cur_ch] = comp[9:0]; // [R21]
            end
            set_flags[cur_ch] = 1'b1; // [R21]
            nxt = next_selected(r.select, r.order); // [R13]
            next_r.cycles = 5'h00;
            if (nxt[4]) begin
              next_r.order = nxt[3:0];
              next_r.state = adcsc_pkg::ADCSC_GAP;
            end else begin
              next_r.state = adcsc_pkg::ADCSC_IDLE;
            end
          end else begin
            next_r.cycles = r.cycles + 5'h01;
          end
        end
      end
      adcsc_pkg::ADCSC_GAP: begin
        if (tick) begin
          if (r.cycles == adcsc_pkg::GAP_CYCLES - 5'h01) begin // [R12]
            next_r.state  = adcsc_pkg::ADCSC_SAMPLE;
            next_r.cycles = 5'h00;
          end else begin
            next_r.cycles = r.cycles + 5'h01;
          end
        end
      end
      default: begin
        next_r.state = adcsc_pkg::ADCSC_IDLE;
      end
    endcase

    // A write to the select word or its high byte aborts everything, then restarts from the walk head if any channel is left selected.
    if (start) begin
      clr_flags     = 16'hffff; // [R18]
      next_r.order  = 4'h0;
      next_r.cycles = 5'h00;
      next_r.offset = 11'h000;
      next_r.state  = ((next_r.select & adcsc_pkg::CHANNEL_MASK) == 16'h0) ?
                      adcsc_pkg::ADCSC_IDLE : adcsc_pkg::ADCSC_COUNT; // [R18]
      set_flags     = 16'h0000;
    end
    next_r.select = next_r.select & adcsc_pkg::CHANNEL_MASK; // [R5]

    // Hardware set wins over a read clear in the same cycle.
    next_r.done = ((r.done & ~clr_flags) | set_flags) &
                  adcsc_pkg::CHANNEL_MASK;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r            <= '0;
      r.state      <= adcsc_pkg::ADCSC_IDLE;
      r.select     <= adcsc_pkg::SELECT_RESET;
      r.config_reg <= adcsc_pkg::CONFIG_RESET;
      r.csense     <= adcsc_pkg::CSENSE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  logic converting;

  assign converting = (r.state == adcsc_pkg::ADCSC_SAMPLE) ||
                      (r.state == adcsc_pkg::ADCSC_CONVERT);

  assign rdata_o  = r.rdata;
  assign rvalid_o = r.rvalid;
  assign busy_o   = (r.state != adcsc_pkg::ADCSC_IDLE);

  always_comb begin
    analog_o.mux_valid   = converting;
    analog_o.mux_sel     = cur_ch; // [R5]
    analog_o.sample      = (r.state == adcsc_pkg::ADCSC_SAMPLE); // [R10]
    analog_o.convert     = (r.state == adcsc_pkg::ADCSC_CONVERT);
    analog_o.sense_on    = r.csense[adcsc_pkg::CS_ON_BIT]; // [R14]
    analog_o.gain_select = r.csense[adcsc_pkg::CS_GAIN_LSB +: 3]; // [R17]
    analog_o.charge_comp = r.csense[adcsc_pkg::CS_ON_BIT] &&
                           !r.csense[adcsc_pkg::CS_CCD_BIT] &&
                           (r.state == adcsc_pkg::ADCSC_SAMPLE) &&
                           (cur_ch == adcsc_pkg::CH_CURRENT_SENSE); // [R15] [R16]
  end

endmodule : adcsc_sequencer

// [test/adcsc_assertions.sv]
// Port checker for the converter sequencer.
// Assumes a bind onto adcsc_sequencer with one clock and sync reset.
`timescale 1ns/100ps
module adcsc_assertions #(
  parameter int CHANNELS = 16
) (
  input wire logic                     ref_clk_i,
  input wire logic                     reset_i,
  input wire adcsc_pkg::adcsc_req_t    req_i,
  input wire logic [15:0]              rdata_o,
  input wire logic                     rvalid_o,
  input wire logic [9:0]               conv_data_i,
  input wire adcsc_pkg::adcsc_analog_t analog_o,
  input wire logic                     busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic       hit;
  logic       rd;
  logic       wr;
  logic       sel_w;
  logic       cs_w;
  logic       div1;
  logic       ccd;
  logic       wr_d;
  logic [7:0] s_cnt;
  logic [7:0] c_cnt;
  assign hit = req_i.valid && req_i.addr[15:9] == 7'h01;
  assign rd = hit && !req_i.write;
  assign wr = hit && req_i.write;
  assign sel_w = wr && req_i.addr[7:0] == adcsc_pkg::OFS_SELECT;
  assign cs_w = wr && req_i.addr[7:0] == adcsc_pkg::OFS_CSENSE;
  // Divider and charge settings are mirrored from the host writes.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div1 <= 1'b0;
      ccd <= 1'b0;
      wr_d <= 1'b0;
      s_cnt <= 8'h00;
      c_cnt <= 8'h00;
    end else begin
      if (wr && req_i.addr[7:0] == adcsc_pkg::OFS_CONFIG) begin
        div1 <= req_i.wdata[2:0] >= 3'h5;
      end
      if (cs_w) begin
        ccd <= req_i.wdata[3];
      end
      wr_d <= sel_w;
      s_cnt <= analog_o.sample ? s_cnt + 8'h01 : 8'h00;
      c_cnt <= analog_o.convert ? c_cnt + 8'h01 : 8'h00;
    end
  end
  sequence gap4;
    (!analog_o.sample)[*4] ##1 analog_o.sample;
  endsequence
  sequence walk1;
    ##1 (busy_o && !analog_o.sample) ##1 analog_o.sample;
  endsequence
  read_answer_a: assert property (rd |=> rvalid_o)
    else $error("read not answered");
  no_stray_a: assert property (!rd |=> !rvalid_o)
    else $error("answer without read");
  sample_len_a: assert property (
    div1 && !wr_d && $fell(analog_o.sample) |-> s_cnt == 8'h09)
    else $error("sample phase length wrong");
  convert_len_a: assert property (
    div1 && !wr_d && $fell(analog_o.convert) |-> c_cnt == 8'h12)
    else $error("convert phase length wrong");
  channel_gap_a: assert property (
    div1 && !wr_d && $fell(analog_o.convert) && busy_o |-> gap4)
    else $error("gap between channels wrong");
  first_sample_a: assert property (
    sel_w && !req_i.byte_acc && req_i.wdata == 16'h8000 && div1 |-> walk1)
    else $error("first sample late");
  stop_seq_a: assert property (
    sel_w && !req_i.byte_acc && req_i.wdata == 16'h0000 |=> !busy_o)
    else $error("zero select did not stop");
  sense_on_a: assert property (
    cs_w |=> analog_o.sense_on == $past(req_i.wdata[7]))
    else $error("sense enable not applied");
  gain_set_a: assert property (
    cs_w |=> analog_o.gain_select == $past(req_i.wdata[2:0]))
    else $error("gain not applied");
  charge_comp_a: assert property (
    analog_o.charge_comp |-> analog_o.sample && analog_o.sense_on && !ccd)
    else $error("charge compensation out of step");
  mux_valid_a: assert property (
    analog_o.mux_valid == (analog_o.sample || analog_o.convert))
    else $error("mux valid out of step");
  mux_hold_a: assert property (
    analog_o.convert |-> $stable(analog_o.mux_sel))
    else $error("channel changed during conversion");
endmodule : adcsc_assertions

bind adcsc_sequencer adcsc_assertions #(.CHANNELS(CHANNELS)) adcsc_assertions_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .conv_data_i(conv_data_i),
  .analog_o(analog_o), .busy_o(busy_o));

// [test/adcsc_sar_model.sv]
// Stand-in for the successive-approximation core.
// Assumes the sequencer samples the raw value on its last convert tick.
`timescale 1ns/100ps
module adcsc_sar_model (
  input  wire logic                     ref_clk_i,
  input  wire adcsc_pkg::adcsc_analog_t analog_i,
  input  wire logic [9:0]               raw_ref_i,
  input  wire logic [9:0]               raw_sig_i,
  output logic [9:0]                    conv_data_o = 10'h155
);
  logic [3:0] ch = 4'h0;
  // Outside a conversion the value is not valid, so it toggles.
  always_ff @(posedge ref_clk_i) begin
    if (analog_i.sample) begin
      ch <= analog_i.mux_sel;
    end
    if (analog_i.convert && ch == adcsc_pkg::CH_CAL_REF) begin
      conv_data_o <= raw_ref_i;
    end else if (analog_i.convert) begin
      conv_data_o <= raw_sig_i;
    end else begin
      conv_data_o <= ~conv_data_o;
    end
  end
endmodule : adcsc_sar_model

// [test/test_adc_sequencer_result_current_sense.sv]
// Self-checking bench for the converter sequencer.
// Assumes the stand-in SAR core and the bound port checker.
`timescale 1ns/100ps
module test_adc_sequencer_result_current_sense;
  logic                     ref_clk_i;
  logic                     reset_i;
  adcsc_pkg::adcsc_req_t    req;
  logic [15:0]              rdata;
  logic                     rvalid;
  logic [9:0]               conv_data;
  adcsc_pkg::adcsc_analog_t analog;
  logic                     busy;
  logic [9:0]               raw_ref;
  logic [9:0]               raw_sig;
  logic [15:0]              q[$];
  logic [15:0]              e;
  logic [3:0]               ms;
  int                       num_errors;
  int                       comparisons;
  int                       cycles;
  int                       n;
  int                       cc;
  int                       v;
  int                       rt[8] = '{10, 8, 6, 4, 2, 1, 1, 1};

  adcsc_sequencer adcsc_sequencer_i (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .conv_data_i(conv_data), .analog_o(analog), .busy_o(busy));
  adcsc_sar_model adcsc_sar_model_i (.ref_clk_i(ref_clk_i),
    .analog_i(analog), .raw_ref_i(raw_ref), .raw_sig_i(raw_sig),
    .conv_data_o(conv_data));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  // A read notes its expected data; the monitor below checks it.
  task automatic acc(input logic w, input logic b, input logic [15:0] a,
                     input logic [15:0] d);
    req = '{1'b1, w, b, a, d};
    if (!w && a[15:9] == 7'h01) q.push_back(d);
    tick;
    req.valid = 1'b0;
    tick;
  endtask : acc

  task automatic run(input logic [15:0] sel);
    acc(1'b1, 1'b0, 16'h0282, sel);
    n = 2;
    cc = 0;
    ms = 4'h0;
    while (busy === 1'b1) begin
      cc += int'(analog.charge_comp);
      if (analog.sample === 1'b1) ms = analog.mux_sel;
      tick;
      n++;
    end
  endtask : run

  always @(negedge ref_clk_i) begin
    if (rvalid === 1'b1) begin
      if (q.size() == 0) chk("rvalid", 16'h0000, 16'h0001);
      else chk("rdata", q.pop_front(), rdata);
    end
  end

  initial begin
    req = '0;
    reset_i = 1'b1;
    raw_ref = 10'h000;
    raw_sig = 10'h000;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    v = $urandom(32'hf445);
    repeat (16) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b0;
    chk("busy", 16'h0000, {15'h0000, busy});
    acc(1'b0, 1'b1, 16'h0280, 16'h0000);
    acc(1'b0, 1'b0, 16'h0282, 16'h0000);
    acc(1'b0, 1'b0, 16'h0384, 16'h0000);
    acc(1'b0, 1'b1, 16'h03b0, 16'h0000);
    acc(1'b0, 1'b0, 16'h0484, 16'h0000);
    for (int g = 0; g < 8; g++) begin
      acc(1'b1, 1'b1, 16'h02b0, 16'(8'h80 | g));
      chk("gain", 16'(g), {13'h0000, analog.gain_select});
      chk("sense_on", 16'h0001, {15'h0000, analog.sense_on});
    end
    acc(1'b0, 1'b1, 16'h02b0, 16'h0087);
    // The first tick lands one to ratio cycles after the start write.
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, 1'b1, 16'h0280, 16'(k));
      run(16'h8000);
      chk("div_lo", 16'h0001, 16'(n > 27 * rt[k] + 1));
      chk("div_hi", 16'h0001, 16'(n <= 28 * rt[k] + 1));
    end
    for (int oc = 0; oc < 2; oc++) begin
      raw_ref = 10'($urandom_range(40, 8));
      raw_sig = 10'($urandom_range(1023, 0));
      v = oc ? raw_sig - raw_ref + 8 : raw_sig;
      v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
      e = 16'(v) << 6;
      acc(1'b1, 1'b1, 16'h0280, oc ? 16'h0025 : 16'h0005);
      run(16'h8400);
      chk("seq_len", 16'h003c, 16'(n));
      acc(1'b0, 1'b0, 16'h0384, 16'h8400);
      acc(1'b0, 1'b0, 16'h02a4, {raw_ref, 6'h00});
      acc(1'b0, 1'b0, 16'h0284, 16'h0400);
      acc(1'b0, 1'b1, 16'h029b, {8'h00, e[7:0]});
      acc(1'b0, 1'b1, 16'h0284, 16'h0004);
      acc(1'b0, 1'b1, 16'h029a, {8'h00, e[15:8]});
      acc(1'b0, 1'b1, 16'h0284, 16'h0000);
    end
    run(16'h0400);
    chk("single_len", 16'h0028, 16'(n));
    chk("mux_sel", 16'h000a, {12'h000, ms});
    for (int d = 0; d < 2; d++) begin
      acc(1'b1, 1'b1, 16'h02b0, d ? 16'h0088 : 16'h0080);
      run(16'h0200);
      chk("charge", d ? 16'h0000 : 16'h0009, 16'(cc));
    end
    acc(1'b1, 1'b1, 16'h0283, 16'h0000);
    acc(1'b0, 1'b0, 16'h0284, 16'h0000);
    acc(1'b1, 1'b1, 16'h0282, 16'h0020);
    chk("bit13", 16'h0000, {15'h0000, busy});
    acc(1'b0, 1'b0, 16'h0282, 16'h0000);
    acc(1'b1, 1'b1, 16'h0282, 16'h0080);
    chk("byte_start", 16'h0001, {15'h0000, busy});
    acc(1'b1, 1'b1, 16'h0280, 16'h0000);
    acc(1'b1, 1'b0, 16'h0282, 16'h8400);
    repeat (400) tick;
    acc(1'b1, 1'b0, 16'h0282, 16'h0000);
    chk("busy", 16'h0000, {15'h0000, busy});
    acc(1'b0, 1'b0, 16'h0284, 16'h0000);
    final_report();
  end
endmodule : test_adc_sequencer_result_current_sense
